// >>> atc_defs.vh
// Register map, field positions, reset values and mode codes
`ifndef ATC_DEFS_VH
`define ATC_DEFS_VH

// Word indices on the register bus
`define ATC_IDX_ERR_HI    4'h0
`define ATC_IDX_ERR_LO    4'h1
`define ATC_IDX_LTH_HI    4'h2
`define ATC_IDX_LTH_LO    4'h3
`define ATC_IDX_UTH_HI    4'h4
`define ATC_IDX_UTH_LO    4'h5
`define ATC_IDX_ACT       4'h6
`define ATC_IDX_CP        4'h7
`define ATC_IDX_THRESHOLD_SETPOINT_HI   4'h8
`define ATC_IDX_THRESHOLD_SETPOINT_LO   4'h9
`define ATC_IDX_CTL3      4'ha
`define ATC_IDX_STAT      4'hb
`define ATC_IDX_IRQ_STAT  4'hc
`define ATC_IDX_IRQ_MASK  4'hd
`define ATC_IDX_CHAN      4'he
`define ATC_IDX_RES_HI    4'hf

// Field positions
`define ATC_CP_EN_BIT     7
`define ATC_CP_RDY_BIT    0
`define ATC_STAT_UP_BIT   6
`define ATC_STAT_LO_BIT   5
`define ATC_CTL3_ERROR_SELECT_A_HI  6
`define ATC_CTL3_ERROR_SELECT_A_LO  4
`define ATC_CTL3_TMD_HI   2
`define ATC_CTL3_TMD_LO   0
`define ATC_IRQ_THR_BIT   0
`define ATC_IRQ_CONV_BIT  1
`define ATC_IRQ_RDY_BIT   2

// Reset values
`define ATC_RST_BYTE      8'h00
`define ATC_RST_WORD      16'h0000
`define ATC_RST_ACT       5'h00
`define ATC_RST_IRQ       3'h0

// Trigger select codes
`define ATC_ACT_OFF       5'h00
`define ATC_ACT_PIN       5'h01
`define ATC_ACT_HW_FIRST  5'h02
`define ATC_ACT_HW_LAST   5'h19
`define ATC_ACT_RD_ERR    5'h1a
`define ATC_ACT_RD_RES    5'h1b
`define ATC_ACT_WR_CHAN   5'h1d

// Error calculation modes
`define ATC_ERROR_SELECT_A_RES_PREV  3'h0
`define ATC_ERROR_SELECT_A_RES_THRESHOLD_SETPOINT  3'h1
`define ATC_ERROR_SELECT_A_FILT_THRESHOLD_SETPOINT 3'h2
`define ATC_ERROR_SELECT_A_FILT_PREV 3'h3

// Threshold interrupt modes
`define ATC_TMD_NEVER     3'h0
`define ATC_TMD_BELOW     3'h1
`define ATC_TMD_NOT_BELOW 3'h2
`define ATC_TMD_INSIDE    3'h3
`define ATC_TMD_OUTSIDE   3'h4
`define ATC_TMD_NOT_ABOVE 3'h5
`define ATC_TMD_ABOVE     3'h6
`define ATC_TMD_ALWAYS    3'h7

`endif

// >>> atc_ctrl.v
// Threshold checking, conversion trigger select and charge pump control
//
// Summary of operation
// - Read-only signed setpoint error, high and low bytes
// - Error computed per error-select field
// - Writable signed lower threshold, reset to zero
// - Writable signed upper threshold, reset to zero
// - Compare error to thresholds, update status flags
// - Threshold mode decides threshold interrupt
// - Five-bit trigger select, upper bits read zero
// - Code zero ignores triggers, one uses pin
// - Codes two to twenty-five pick hardware sources
// - Pin-change trigger is OR of all flags
// - Reads of result or error high start conversion
// - Channel select write starts conversion
// - Pump on when enabled and requested
// - Read-only pump ready in bit zero
// - Setpoint may be an error operand
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "atc_defs.vh"

module atc_ctrl #(
    parameter IOC_W = 8
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              reset_n,
    // Avalon-MM slave, word addressed
    input  wire [3:0]        avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    input  wire [3:0]        avs_byteenable,
    output reg  [31:0]       avs_readdata,
    output reg               avs_waitrequest,
    // Converter side, same clock
    input  wire              conv_done,
    input  wire [15:0]       conv_result,
    input  wire [15:0]       conv_prev,
    input  wire [15:0]       conv_filter,
    output reg               conv_start_r,
    // Trigger sources
    input  wire              trig_pin,
    input  wire [22:0]       hw_trig,
    input  wire [IOC_W-1:0]  pin_change_interrupt,
    // Charge pump
    input  wire              pump_request,
    input  wire              pump_ready_pin,
    output reg               pump_on_r,
    // Interrupt
    output reg               irq_r
);

    reg  [15:0] error_r;
    reg  [15:0] lower_threshold_r;
    reg  [15:0] upper_threshold_r;
    reg  [15:0] threshold_setpoint_r;
    reg  [4:0]  trigger_select_r;
    reg         pump_enable_r;
    reg  [2:0]  error_select_a_r;
    reg  [2:0]  threshold_interrupt_mode_r;
    reg         above_upper_flag_r;
    reg         below_lower_flag_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_mask_r;
    reg  [5:0]  chan_r;
    reg  [2:0]  pin_sync_r;
    reg         pin_lvl_r;
    reg  [2:0]  rdy_sync_r;
    reg         pump_ready_r;
    reg  [23:0] hw_prev_r;

    wire        wr_done;
    wire        rd_done;
    wire        lane0;
    wire [7:0]  wbyte;
    wire        wr_lane;
    wire        irq_clr;
    wire        ioc_any;
    wire [23:0] hw_vec;
    wire [23:0] hw_rise;
    wire        pin_rise;
    wire        sw_err_rd;
    wire        sw_res_rd;
    wire        sw_ch_wr;
    wire [15:0] err_nxt;
    wire        below_nxt;
    wire        above_nxt;
    wire        thr_hit;
    reg         trig_hit;
    reg  [7:0]  rd_mux;
    reg  [2:0]  irq_set;
    reg  [2:0]  irq_stat_nxt;
    wire        pin_lvl_nxt;
    wire        pump_ready_nxt;

    // Signed compare used for both thresholds
    function lt16;
        input [15:0] a;
        input [15:0] b;
        begin
            lt16 = ($signed(a) < $signed(b));
        end
    endfunction

    function [15:0] err_error_select_a;
        input [2:0]  sel;
        input [15:0] res;
        input [15:0] prv;
        input [15:0] flt;
        input [15:0] stp;
        begin
            case (sel)
                `ATC_ERROR_SELECT_A_RES_PREV:  err_error_select_a = res - prv;
                `ATC_ERROR_SELECT_A_RES_THRESHOLD_SETPOINT:  err_error_select_a = res - stp;
                `ATC_ERROR_SELECT_A_FILT_THRESHOLD_SETPOINT: err_error_select_a = flt - stp;
                `ATC_ERROR_SELECT_A_FILT_PREV: err_error_select_a = flt - prv;
                default:             err_error_select_a = res - stp;
            endcase
        end
    endfunction

    function tmd_hit;
        input [2:0] mode;
        input       below;
        input       above;
        begin
            case (mode)
                `ATC_TMD_NEVER:     tmd_hit = 1'b0;
                `ATC_TMD_BELOW:     tmd_hit = below;
                `ATC_TMD_NOT_BELOW: tmd_hit = ~below;
                `ATC_TMD_INSIDE:    tmd_hit = ~below & ~above;
                `ATC_TMD_OUTSIDE:   tmd_hit = below | above;
                `ATC_TMD_NOT_ABOVE: tmd_hit = ~above;
                `ATC_TMD_ABOVE:     tmd_hit = above;
                `ATC_TMD_ALWAYS:    tmd_hit = 1'b1;
                default:            tmd_hit = 1'b0;
            endcase
        end
    endfunction

    // Strobe decode for one word index; shared by the side effects
    function bus_hit;
        input       done;
        input [3:0] addr;
        input [3:0] idx;
        begin
            bus_hit = done & (addr == idx);
        end
    endfunction

    // One wait state: the access completes while waitrequest is low
    assign wr_done = avs_write & ~avs_waitrequest;
    assign rd_done = avs_read & ~avs_waitrequest;
    assign lane0   = avs_byteenable[0];
    assign wbyte   = avs_writedata[7:0];
    // Only lane 0 carries a byte; a write without it changes nothing
    assign wr_lane = wr_done & lane0;

    // Low for one cycle per access; a request still held at the
    // completing edge sees it high again, so each access costs two
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            avs_waitrequest <= 1'b1;
        else if ((avs_read | avs_write) & avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    always @*
    begin
        rd_mux = 8'h00;
        case (avs_address)
            `ATC_IDX_ERR_HI:   rd_mux = error_r[15:8];
            `ATC_IDX_ERR_LO:   rd_mux = error_r[7:0];
            `ATC_IDX_LTH_HI:   rd_mux = lower_threshold_r[15:8];
            `ATC_IDX_LTH_LO:   rd_mux = lower_threshold_r[7:0];
            `ATC_IDX_UTH_HI:   rd_mux = upper_threshold_r[15:8];
            `ATC_IDX_UTH_LO:   rd_mux = upper_threshold_r[7:0];
            `ATC_IDX_ACT:      rd_mux = {3'h0, trigger_select_r};
            `ATC_IDX_CP:
            begin
                rd_mux[`ATC_CP_EN_BIT]  = pump_enable_r;
                rd_mux[`ATC_CP_RDY_BIT] = pump_ready_r;
            end
            `ATC_IDX_THRESHOLD_SETPOINT_HI:  rd_mux = threshold_setpoint_r[15:8];
            `ATC_IDX_THRESHOLD_SETPOINT_LO:  rd_mux = threshold_setpoint_r[7:0];
            `ATC_IDX_CTL3:     rd_mux = {1'b0, error_select_a_r, 1'b0,
                                         threshold_interrupt_mode_r};
            `ATC_IDX_STAT:
            begin
                rd_mux[`ATC_STAT_UP_BIT] = above_upper_flag_r;
                rd_mux[`ATC_STAT_LO_BIT] = below_lower_flag_r;
            end
            `ATC_IDX_IRQ_STAT: rd_mux = {5'h00, irq_stat_r};
            `ATC_IDX_IRQ_MASK: rd_mux = {5'h00, irq_mask_r};
            `ATC_IDX_CHAN:     rd_mux = {2'h0, chan_r};
            `ATC_IDX_RES_HI:   rd_mux = conv_result[15:8];
            default:           rd_mux = 8'h00;
        endcase
    end

    // Read data sampled when the request is first seen
    // and held through the low cycle of waitrequest
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            avs_readdata <= 32'h00000000;
        else if (avs_read & avs_waitrequest)
            avs_readdata <= {24'h000000, rd_mux};
    end

    // Writable registers; error, ready and status have no write path
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lower_threshold_r          <= `ATC_RST_WORD;
            upper_threshold_r          <= `ATC_RST_WORD;
            threshold_setpoint_r       <= `ATC_RST_WORD;
            trigger_select_r           <= `ATC_RST_ACT;
            pump_enable_r              <= 1'b0;
            error_select_a_r           <= 3'h0;
            threshold_interrupt_mode_r <= 3'h0;
            irq_mask_r                 <= `ATC_RST_IRQ;
            chan_r                     <= 6'h00;
        end
        else if (wr_lane)
        begin
            case (avs_address)
                `ATC_IDX_LTH_HI:   lower_threshold_r[15:8] <= wbyte;
                `ATC_IDX_LTH_LO:   lower_threshold_r[7:0]  <= wbyte;
                `ATC_IDX_UTH_HI:   upper_threshold_r[15:8] <= wbyte;
                `ATC_IDX_UTH_LO:   upper_threshold_r[7:0]  <= wbyte;
                `ATC_IDX_THRESHOLD_SETPOINT_HI:  threshold_setpoint_r[15:8] <= wbyte;
                `ATC_IDX_THRESHOLD_SETPOINT_LO:  threshold_setpoint_r[7:0]  <= wbyte;
                `ATC_IDX_ACT:      trigger_select_r <= wbyte[4:0];
                `ATC_IDX_CP:
                    pump_enable_r <= wbyte[`ATC_CP_EN_BIT];
                `ATC_IDX_CTL3:
                begin
                    error_select_a_r <=
                        wbyte[`ATC_CTL3_ERROR_SELECT_A_HI:`ATC_CTL3_ERROR_SELECT_A_LO];
                    threshold_interrupt_mode_r <=
                        wbyte[`ATC_CTL3_TMD_HI:`ATC_CTL3_TMD_LO];
                end
                `ATC_IDX_IRQ_MASK: irq_mask_r <= wbyte[2:0];
                `ATC_IDX_CHAN:     chan_r <= wbyte[5:0];
                default:           chan_r <= chan_r;
            endcase
        end
    end

    // Error and threshold status flags updated on each finished conversion
    assign err_nxt   = err_error_select_a(error_select_a_r, conv_result, conv_prev,
                                conv_filter, threshold_setpoint_r);
    assign above_nxt = lt16(upper_threshold_r, err_nxt);
    assign below_nxt = lt16(err_nxt, lower_threshold_r);
    assign thr_hit   = conv_done &
        tmd_hit(threshold_interrupt_mode_r, below_nxt, above_nxt);

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Zero rather than unknown so a read after reset is defined
            error_r            <= `ATC_RST_WORD;
            above_upper_flag_r <= 1'b0;
            below_lower_flag_r <= 1'b0;
        end
        else if (conv_done)
        begin
            error_r            <= err_nxt;
            above_upper_flag_r <= above_nxt;
            below_lower_flag_r <= below_nxt;
        end
    end

    // Pin and ready come from outside: three stages, second and third
    // must agree before the level moves, so one glitchy sample is dropped
    assign pin_lvl_nxt = (pin_sync_r[1] == pin_sync_r[2]) ?
                         pin_sync_r[2] : pin_lvl_r;
    assign pump_ready_nxt = (rdy_sync_r[1] == rdy_sync_r[2]) ?
                            rdy_sync_r[2] : pump_ready_r;

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_sync_r   <= 3'h0;
            pin_lvl_r    <= 1'b0;
            rdy_sync_r   <= 3'h0;
            pump_ready_r <= 1'b0;
            hw_prev_r    <= 24'h000000;
        end
        else
        begin
            pin_sync_r   <= {pin_sync_r[1:0], trig_pin};
            pin_lvl_r    <= pin_lvl_nxt;
            rdy_sync_r   <= {rdy_sync_r[1:0], pump_ready_pin};
            pump_ready_r <= pump_ready_nxt;
            hw_prev_r    <= hw_vec;
        end
    end

    // Trigger source selection
    assign ioc_any   = |pin_change_interrupt;
    assign hw_vec    = {hw_trig[22:19], ioc_any, hw_trig[18:0]};
    // Rising edges only: a source held high starts one conversion
    assign hw_rise   = hw_vec & ~hw_prev_r;
    assign pin_rise  = pin_lvl_nxt & ~pin_lvl_r;
    // Software triggers fire on the completing edge, never on a held
    // request, so one access starts exactly one conversion
    assign sw_err_rd = bus_hit(rd_done, avs_address,
                               `ATC_IDX_ERR_HI);
    assign sw_res_rd = bus_hit(rd_done, avs_address,
                               `ATC_IDX_RES_HI);
    assign sw_ch_wr  = bus_hit(wr_lane, avs_address,
                               `ATC_IDX_CHAN);
    assign irq_clr   = bus_hit(wr_lane, avs_address,
                               `ATC_IDX_IRQ_STAT);

    // Reserved codes simply never fire
    always @*
    begin
        trig_hit = 1'b0;
        case (trigger_select_r)
            `ATC_ACT_OFF:     trig_hit = 1'b0;
            `ATC_ACT_PIN:     trig_hit = pin_rise;
            `ATC_ACT_RD_ERR:  trig_hit = sw_err_rd;
            `ATC_ACT_RD_RES:  trig_hit = sw_res_rd;
            `ATC_ACT_WR_CHAN: trig_hit = sw_ch_wr;
            default:
                if (trigger_select_r >= `ATC_ACT_HW_FIRST &&
                    trigger_select_r <= `ATC_ACT_HW_LAST)
                    trig_hit = hw_rise[trigger_select_r -
                                       `ATC_ACT_HW_FIRST];
                else
                    trig_hit = 1'b0;
        endcase
    end

    // Sticky interrupt status; a new event beats a same-cycle clear
    always @*
    begin
        irq_set = 3'h0;
        irq_set[`ATC_IRQ_THR_BIT]  = thr_hit;
        irq_set[`ATC_IRQ_CONV_BIT] = trig_hit;
        irq_set[`ATC_IRQ_RDY_BIT]  = pump_ready_nxt & ~pump_ready_r;
        irq_stat_nxt = irq_stat_r;
        if (irq_clr)
            irq_stat_nxt = irq_stat_r & ~wbyte[2:0];
        irq_stat_nxt = irq_stat_nxt | irq_set;
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_stat_r   <= `ATC_RST_IRQ;
            irq_r        <= 1'b0;
            conv_start_r <= 1'b0;
            pump_on_r    <= 1'b0;
        end
        else
        begin
            irq_stat_r   <= irq_stat_nxt;
            irq_r        <= |(irq_stat_nxt & irq_mask_r);
            conv_start_r <= trig_hit;
            pump_on_r    <= pump_enable_r & pump_request;
        end
    end

endmodule

// >>> atc_ctrl_tail.v
// Holds no logic; the whole controller sits in atc_ctrl.v

// >>> atc_ctrl_chk.sv
// Bound property checker for the threshold and trigger controller
`timescale 1ns/1ns
module atc_ctrl_chk #(
    parameter IOC_W = 8
) (
    // Clock, reset and register bus
    input wire             mclk,
    input wire             reset_n,
    input wire [3:0]       avs_address,
    input wire             avs_read,
    input wire             avs_write,
    input wire [31:0]      avs_writedata,
    input wire [3:0]       avs_byteenable,
    input wire [31:0]      avs_readdata,
    input wire             avs_waitrequest,
    // Converter, triggers, pump and interrupt
    input wire             conv_done,
    input wire [15:0]      conv_result,
    input wire [15:0]      conv_prev,
    input wire [15:0]      conv_filter,
    input wire             conv_start_r,
    input wire             trig_pin,
    input wire [22:0]      hw_trig,
    input wire [IOC_W-1:0] pin_change_interrupt,
    input wire             pump_request,
    input wire             pump_ready_pin,
    input wire             pump_on_r,
    input wire             irq_r
);
    reg  [4:0] act_r;
    reg  [2:0] mask_r;
    reg        cp_en_r;
    wire       wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire       rd_ok = avs_read && !avs_waitrequest;
    wire       rd_req = avs_read && avs_waitrequest;
    wire [4:0] hw_idx = (act_r <= 5'h14) ? act_r - 5'h02 : act_r - 5'h03;
    wire       hw_code = act_r >= 5'h02 && act_r <= 5'h19 && act_r != 5'h15;
    wire       hw_sel = hw_trig[hw_idx];
    wire       pump_want = cp_en_r && pump_request;

    // Shadows of fields the ports cannot show
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            act_r   <= 5'h00;
            mask_r  <= 3'h0;
            cp_en_r <= 1'h0;
        end
        else if (wr_ok)
        begin
            if (avs_address == 4'h6)
                act_r <= avs_writedata[4:0];
            if (avs_address == 4'hd)
                mask_r <= avs_writedata[2:0];
            if (avs_address == 4'h7)
                cp_en_r <= avs_writedata[7];
        end
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_act_upper: assert property (rd_req && avs_address == 4'h6
        |=> avs_readdata[7:5] == 3'h0) else $error("select high bits set");
    chk_off_quiet: assert property (act_r == 5'h00
        && $past(act_r) == 5'h00 |-> !conv_start_r)
        else $error("start while triggers off");
    chk_pin_start: assert property (act_r == 5'h01 && $rose(trig_pin)
        |-> ##[2:6] conv_start_r) else $error("pin rise gave no start");
    chk_hw_start: assert property (hw_code && $stable(act_r)
        && $rose(hw_sel) |-> ##[1:3] conv_start_r)
        else $error("hardware source gave no start");
    chk_read_start: assert property (rd_ok && (
        (avs_address == 4'hf && act_r == 5'h1b) ||
        (avs_address == 4'h0 && act_r == 5'h1a)) |=> conv_start_r)
        else $error("trigger read gave no start");
    chk_chan_start: assert property (wr_ok && avs_address == 4'he
        && act_r == 5'h1d |=> conv_start_r) else $error("no channel start");
    chk_pump_gate: assert property (pump_on_r == $past(pump_want))
        else $error("pump output wrong");
    chk_irq_masked: assert property (mask_r == 3'h0
        && $past(mask_r) == 3'h0 |-> !irq_r) else $error("masked irq high");

    cov_start: cover property (conv_start_r);
    cov_irq: cover property ($rose(irq_r));
    cov_pump: cover property ($rose(pump_on_r));
endmodule

bind atc_ctrl atc_ctrl_chk #(.IOC_W(IOC_W)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_done(conv_done), .conv_result(conv_result),
    .conv_prev(conv_prev), .conv_filter(conv_filter),
    .conv_start_r(conv_start_r), .trig_pin(trig_pin), .hw_trig(hw_trig),
    .pin_change_interrupt(pin_change_interrupt),
    .pump_request(pump_request), .pump_ready_pin(pump_ready_pin),
    .pump_on_r(pump_on_r), .irq_r(irq_r));

// >>> atc_ctrl_tb_top.sv
// Self-checking bench for the threshold and trigger controller
`timescale 1ns/1ns
module atc_ctrl_tb_top;
    reg         mclk = 1'h0;
    reg         reset_n = 1'h0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'h0;
    reg         avs_write = 1'h0;
    reg  [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    reg         conv_done = 1'h0;
    reg  [15:0] conv_result = 16'h0;
    reg  [15:0] conv_prev = 16'h0;
    wire        conv_start_r;
    reg         trig_pin = 1'h0;
    reg  [22:0] hw_trig = 23'h0;
    reg  [7:0]  pin_chg = 8'h0;
    reg         pump_request = 1'h0;
    reg         pump_ready_pin = 1'h0;
    wire        pump_on_r;
    wire        irq_r;
    integer     num_errors = 0;
    integer     compares = 0;
    integer     cycles = 0;
    integer     c;
    integer     n;
    reg  [7:0]  d;
    reg  [7:0]  tmd_exp = 8'hd4;
    reg  [19:0] rows [0:7];

    always #50 mclk = ~mclk;

    atc_ctrl #(.IOC_W(8)) u_dut (
        .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .conv_done(conv_done), .conv_result(conv_result),
        .conv_prev(conv_prev), .conv_filter(16'h1234),
        .conv_start_r(conv_start_r), .trig_pin(trig_pin), .hw_trig(hw_trig),
        .pin_change_interrupt(pin_chg), .pump_request(pump_request),
        .pump_ready_pin(pump_ready_pin), .pump_on_r(pump_on_r),
        .irq_r(irq_r));

    task end_of_test;
    begin
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    task chk(input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask

    // Request held until waitrequest is sampled low
    task bus(input rw, input [3:0] a, input [7:0] wd, output [7:0] rd);
    begin
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= {24'h0, wd};
        avs_write     <= rw;
        avs_read      <= !rw;
        @(posedge mclk);
        while (avs_waitrequest !== 1'h0)
            @(posedge mclk);
        rd = avs_readdata[7:0];
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
    end
    endtask

    task rdc(input [3:0] a, input [7:0] exp);
    begin
        bus(1'h0, a, 8'h0, d);
        chk(d, exp);
    end
    endtask

    task conv(input [15:0] r, input [15:0] p);
    begin
        @(posedge mclk);
        conv_result <= r;
        conv_prev   <= p;
        conv_done   <= 1'h1;
        @(posedge mclk);
        conv_done   <= 1'h0;
    end
    endtask

    task count_starts(input [31:0] exp);
    begin
        n = 0;
        repeat (8) @(posedge mclk) n = n + (conv_start_r === 1'h1);
        chk(n, exp);
        trig_pin <= 1'h0;
        hw_trig  <= 23'h0;
        pin_chg  <= 8'h0;
        repeat (6) @(posedge mclk);
    end
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    end

    initial
    begin
        rows[0] = {4'h2, 8'h80, 8'h80};
        rows[1] = {4'h3, 8'h01, 8'h01};
        rows[2] = {4'h4, 8'h7f, 8'h7f};
        rows[3] = {4'h5, 8'hfe, 8'hfe};
        rows[4] = {4'h6, 8'hf9, 8'h19};
        rows[5] = {4'h7, 8'hff, 8'h80};
        rows[6] = {4'h0, 8'h55, 8'h00};
        rows[7] = {4'h1, 8'haa, 8'h00};
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        for (c = 0; c < 8; c = c + 1)
        begin
            bus(1'h1, rows[c][19:16], rows[c][15:8], d);
            rdc(rows[c][19:16], rows[c][7:0]);
        end
        // Second reset must clear what the rows wrote
        reset_n <= 1'h0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        for (c = 0; c < 8; c = c + 1)
            rdc(c[3:0], 8'h00);
        bus(1'h1, 4'h2, 8'hff, d);
        bus(1'h1, 4'h3, 8'hf0, d);
        bus(1'h1, 4'h5, 8'h10, d);
        bus(1'h1, 4'ha, 8'h01, d);
        bus(1'h1, 4'hd, 8'h01, d);
        conv(16'h0064, 16'h0032);
        rdc(4'h1, 8'h32);
        rdc(4'hb, 8'h40);
        chk(irq_r, 1'h0);
        conv(16'h0000, 16'h0064);
        rdc(4'h0, 8'hff);
        rdc(4'h1, 8'h9c);
        rdc(4'hb, 8'h20);
        chk(irq_r, 1'h1);
        bus(1'h1, 4'hc, 8'h01, d);
        repeat (2) @(posedge mclk);
        chk(irq_r, 1'h0);
        // Equal to a threshold is neither above nor below
        conv(16'h0010, 16'h0000);
        rdc(4'hb, 8'h00);
        bus(1'h1, 4'ha, 8'h11, d);
        bus(1'h1, 4'h9, 8'h10, d);
        conv(16'h0005, 16'h7fff);
        rdc(4'h1, 8'hf5);
        rdc(4'hb, 8'h00);
        // Every threshold mode against an error above the upper bound
        for (c = 0; c < 8; c = c + 1)
        begin
            bus(1'h1, 4'ha, c[7:0], d);
            bus(1'h1, 4'hc, 8'h07, d);
            conv(16'h0064, 16'h0032);
            rdc(4'hc, {7'h0, tmd_exp[c]});
        end
        // Filtered value against setpoint, then against previous
        bus(1'h1, 4'ha, 8'h20, d);
        conv(16'h0000, 16'h0000);
        rdc(4'h1, 8'h24);
        bus(1'h1, 4'ha, 8'h30, d);
        conv(16'h0000, 16'h0034);
        rdc(4'h0, 8'h12);
        // All sources but the error-high read active while triggers are off
        conv_result <= 16'h12ab;
        trig_pin <= 1'h1;
        hw_trig  <= 23'h7fffff;
        pin_chg  <= 8'hff;
        rdc(4'hf, 8'h12);
        bus(1'h1, 4'he, 8'h03, d);
        count_starts(0);
        // Reserved code 0x1c is never programmed
        for (c = 1; c < 30; c = c + 1)
            if (c != 28)
            begin
                bus(1'h1, 4'h6, c[7:0], d);
                // Let the new code settle before the source moves
                @(posedge mclk);
                case (c)
                    1: trig_pin <= 1'h1;
                    21: pin_chg <= 8'h08;
                    26: bus(1'h0, 4'h0, 8'h0, d);
                    27: bus(1'h0, 4'hf, 8'h0, d);
                    29: bus(1'h1, 4'he, 8'h05, d);
                    default: hw_trig <= 23'h1 << (c <= 20 ? c - 2 : c - 3);
                endcase
                count_starts(1);
            end
        bus(1'h1, 4'h7, 8'h80, d);
        pump_request <= 1'h1;
        repeat (3) @(posedge mclk);
        chk(pump_on_r, 1'h1);
        bus(1'h1, 4'h7, 8'h00, d);
        pump_ready_pin <= 1'h1;
        repeat (6) @(posedge mclk);
        chk(pump_on_r, 1'h0);
        rdc(4'h7, 8'h01);
        rdc(4'hc, 8'h07);
        chk(irq_r, 1'h1);
        bus(1'h1, 4'hd, 8'h00, d);
        repeat (2) @(posedge mclk);
        chk(irq_r, 1'h0);
        end_of_test;
    end
endmodule
